//--- verification/agoc_monitor.sv
module agoc_monitor #(
  parameter int EST_LIMIT = 10
) (
  // APB side
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Sample side
  input wire logic signed [10:0] ch_a_sample,
  input wire logic signed [10:0] ch_b_sample,
  input wire logic [10:0]        cmos_a_data,
  input wire logic [10:0]        cmos_b_data,
  input wire logic [5:0]         lvds_a_rise,
  input wire logic [5:0]         lvds_a_fall,
  input wire logic [5:0]         lvds_b_rise,
  input wire logic [5:0]         lvds_b_fall,
  input wire logic               lvds_mode,
  input wire logic               out_clk_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Pass-through tracking
  // The path is a plain copy while the gain mode is off; the run count
  // waits out the three-stage pipeline after reset or after the gain mode turns off.
  logic       plain_q;
  logic [2:0] run_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plain_q <= 1'h1;
    end else if (psel && penable && pwrite && paddr == agoc_pkg::ADDR_MODE) begin
      plain_q <= !(pwdata[0] && pwdata[1]);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 3'h0;
    end else if (!plain_q) begin
      run_q <= 3'h0;
    end else if (run_q != 3'h7) begin
      run_q <= run_q + 3'h1;
    end
  end
  function automatic logic [11:0] weave(input logic [5:0] r, input logic [5:0] f);
    for (int k = 0; k < 6; k++) begin
      weave[2*k] = r[k];
      weave[2*k+1] = f[k];
    end
  endfunction
  // ==========================================================================
  // Assertions
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  access_ready_a: assert property (psel && penable |-> pready)
    else $error("pready low in an access cycle");
  unmapped_err_a: assert property (psel && penable && paddr > agoc_pkg::ADDR_EST_B |-> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (psel && penable && paddr <= agoc_pkg::ADDR_EST_B
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped address");
  err_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  est_bound_a: assert property (psel && penable && !pwrite
    && (paddr == agoc_pkg::ADDR_EST_A || paddr == agoc_pkg::ADDR_EST_B)
    |-> $signed(prdata[10:0]) <= EST_LIMIT
    && $signed(prdata[10:0]) >= -EST_LIMIT) else $error("estimate beyond limit");
  cmos_quiet_a: assert property (lvds_mode |-> cmos_a_data == 11'h0
    && cmos_b_data == 11'h0) else $error("parallel pins active in pair mode");
  pair_quiet_a: assert property (!lvds_mode |-> (lvds_a_rise | lvds_a_fall | lvds_b_rise
    | lvds_b_fall) == 6'h0) else $error("pairs active in parallel mode");
  clk_fwd_a: assert property ($past(presetn) |-> out_clk_en)
    else $error("output clock not enabled after reset");
  cmos_pass_a: assert property (!lvds_mode && run_q >= 3'h4 |->
    cmos_a_data == $past(ch_a_sample, 3) && cmos_b_data == $past(ch_b_sample, 3))
    else $error("parallel word differs from sample");
  pair_pass_a: assert property (lvds_mode && run_q >= 3'h4 |->
    weave(lvds_a_rise, lvds_a_fall) == {1'h0, $past(ch_a_sample, 3)}
    && weave(lvds_b_rise, lvds_b_fall) == {1'h0, $past(ch_b_sample, 3)})
    else $error("pair bits differ from sample");
  cover property (lvds_mode && run_q >= 3'h4);
  cover property (!lvds_mode && run_q >= 3'h4);
  cover property (psel && penable && pslverr);
endmodule // agoc_monitor

bind agoc_top agoc_monitor #(.EST_LIMIT(EST_LIMIT)) agoc_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ch_a_sample(ch_a_sample), .ch_b_sample(ch_b_sample), .cmos_a_data(cmos_a_data),
  .cmos_b_data(cmos_b_data), .lvds_a_rise(lvds_a_rise), .lvds_a_fall(lvds_a_fall),
  .lvds_b_rise(lvds_b_rise), .lvds_b_fall(lvds_b_fall), .lvds_mode(lvds_mode),
  .out_clk_en(out_clk_en)
);

//--- verification/agoc_rx_model.sv
module agoc_rx_model (
  // Clock and interface select
  input  wire logic        pclk,
  input  wire logic        out_clk_en,
  input  wire logic        lvds_mode,
  // Parallel data
  input  wire logic [10:0] cmos_a_data,
  input  wire logic [10:0] cmos_b_data,
  // Double data rate pairs
  input  wire logic [5:0]  lvds_a_rise,
  input  wire logic [5:0]  lvds_a_fall,
  input  wire logic [5:0]  lvds_b_rise,
  input  wire logic [5:0]  lvds_b_fall,
  // Captured words
  output logic [10:0]      word_a,
  output logic [10:0]      word_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Capture
  // Rising edge latch
  always @(posedge pclk) begin
    if (out_clk_en) begin
      for (int k = 0; k < 11; k++) begin
        word_a[k] <= !lvds_mode ? cmos_a_data[k]
                   : (k % 2) ? lvds_a_fall[k/2] : lvds_a_rise[k/2];
        word_b[k] <= !lvds_mode ? cmos_b_data[k]
                   : (k % 2) ? lvds_b_fall[k/2] : lvds_b_rise[k/2];
      end
    end
  end
endmodule // agoc_rx_model

//--- verification/test_adc_gain_offset_correction.sv
module test_adc_gain_offset_correction;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EST_LIM = 3;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic signed [10:0] smp_a, smp_b;
  logic [10:0]        cmos_a, cmos_b, word_a, word_b;
  logic [5:0]         ar, af, br, bf;
  logic               lvds_mode, clk_en;
  int                 fails, samples_checked, n;

  agoc_top #(.EST_LIMIT(EST_LIM)) agoc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch_a_sample(smp_a), .ch_b_sample(smp_b), .cmos_a_data(cmos_a), .cmos_b_data(cmos_b),
    .lvds_a_rise(ar), .lvds_a_fall(af), .lvds_b_rise(br), .lvds_b_fall(bf),
    .lvds_mode(lvds_mode), .out_clk_en(clk_en)
  );
  agoc_rx_model agoc_rx_model_inst (
    .pclk(pclk), .out_clk_en(clk_en), .lvds_mode(lvds_mode), .cmos_a_data(cmos_a),
    .cmos_b_data(cmos_b), .lvds_a_rise(ar), .lvds_a_fall(af), .lvds_b_rise(br),
    .lvds_b_fall(bf), .word_a(word_a), .word_b(word_b)
  );
  // ==========================================================================
  // Tasks
  task automatic final_report();
    $display("checks made %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_word(input string nm, input logic [10:0] e, input logic [10:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A slave that never answers would hang the run, so the wait is bounded.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (k == 16) begin
      fails++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check_reg(nm, e, rd);
  endtask
  task automatic put(input logic [10:0] a, input logic [10:0] b);
    @(posedge pclk);
    smp_a <= a;
    smp_b <= b;
    repeat (6) @(posedge pclk);
  endtask
  function automatic logic [10:0] gexp(input int x, input int code);
    int f;
    int y;
    f = $rtoi(4096.0 * 10.0 ** (code / 40.0) + 0.5);
    y = (x * f) >>> 12;
    gexp = (y > 1023) ? 11'h3FF : (y < -1024) ? 11'h400 : y[10:0];
  endfunction
  // ==========================================================================
  // Sequence
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, smp_a, smp_b} = '0;
    fails = 0;
    samples_checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk("mode", agoc_pkg::ADDR_MODE, 32'h4);
    rd_chk("dc ctrl", agoc_pkg::ADDR_DC_CTRL, 32'h0);
    rd_chk("status", agoc_pkg::ADDR_STATUS, 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    check_reg("unmapped", 32'h1, {31'h0, err});
    apb(1'h1, agoc_pkg::ADDR_GAIN, 32'hC);
    rd_chk("gain locked", agoc_pkg::ADDR_GAIN, 32'h0);
    apb(1'h1, agoc_pkg::ADDR_DC_CTRL, 32'h1);
    rd_chk("dc needs mode", agoc_pkg::ADDR_STATUS, 32'h0);
    apb(1'h1, agoc_pkg::ADDR_DC_CTRL, 32'h0);
    apb(1'h1, agoc_pkg::ADDR_MODE, 32'h0);
    put(11'h155, 11'h2AA);
    check_word("cmos a", 11'h155, word_a);
    check_word("cmos b", 11'h2AA, word_b);
    apb(1'h1, agoc_pkg::ADDR_MODE, 32'h4);
    put(11'h2AA, 11'h555);
    check_word("pair a", 11'h2AA, word_a);
    check_word("pair b", 11'h555, word_b);
    $display("test reset and interfaces done");
    apb(1'h1, agoc_pkg::ADDR_MODE, 32'h3);
    rd_chk("gain on", agoc_pkg::ADDR_STATUS, 32'h1);
    rd_chk("gain 0 dB", agoc_pkg::ADDR_GAIN, 32'h0);
    for (n = 0; n <= 12; n++) begin
      apb(1'h1, agoc_pkg::ADDR_GAIN, 32'(n));
      put(11'h100, 11'h3F0);
      check_word("gain a", gexp(256, n), word_a);
      check_word("gain sat", gexp(1008, n), word_b);
    end
    put(11'h200, 11'h400);
    check_word("6 dB scale", 11'h3FD, word_a);
    check_word("6 dB low", 11'h400, word_b);
    apb(1'h1, agoc_pkg::ADDR_GAIN, 32'hD);
    rd_chk("gain clamp", agoc_pkg::ADDR_GAIN, 32'hC);
    // Re-arming the mode must bring a nonzero code back to 0 dB.
    apb(1'h1, agoc_pkg::ADDR_MODE, 32'h0);
    apb(1'h1, agoc_pkg::ADDR_MODE, 32'h3);
    rd_chk("gain rearmed", agoc_pkg::ADDR_GAIN, 32'h0);
    $display("test gain done");
    apb(1'h1, agoc_pkg::ADDR_DC_CTRL, 32'hB1);
    put(11'h3FF, 11'h3FF);
    repeat (1500) @(posedge pclk);
    rd_chk("slow loop", agoc_pkg::ADDR_EST_A, 32'h0);
    apb(1'h1, agoc_pkg::ADDR_DC_CTRL, 32'hC1);
    rd_chk("reserved rate", agoc_pkg::ADDR_STATUS, 32'h7);
    apb(1'h1, agoc_pkg::ADDR_DC_CTRL, 32'h1);
    n = 0;
    do begin
      apb(1'h0, agoc_pkg::ADDR_EST_A, 32'h0);
      n++;
    end while (rd !== 32'(EST_LIM) && n < 3000);
    if (n == 3000) begin
      fails++;
      final_report();
    end
    rd_chk("est b", agoc_pkg::ADDR_EST_B, 32'(EST_LIM));
    check_word("corrected", 11'h3FC, word_a);
    $display("test offset loop done");
    apb(1'h1, agoc_pkg::ADDR_DC_CTRL, 32'h3);
    put(11'h400, 11'h000);
    repeat (2000) @(posedge pclk);
    rd_chk("held est", agoc_pkg::ADDR_EST_A, 32'(EST_LIM));
    rd_chk("held flag", agoc_pkg::ADDR_STATUS, 32'hB);
    check_word("held sat", 11'h400, word_a);
    check_word("held sub", 11'h7FD, word_b);
    apb(1'h1, agoc_pkg::ADDR_DC_CTRL, 32'h0);
    rd_chk("est cleared", agoc_pkg::ADDR_EST_A, 32'h0);
    put(11'h400, 11'h000);
    check_word("bypass", 11'h000, word_b);
    $display("test hold and clear done");
    final_report();
  end
endmodule // test_adc_gain_offset_correction

//--- verilog/agoc_dc_loop.sv
module agoc_dc_loop #(
  parameter int EST_LIMIT = 10
) (
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  // Control
  input  wire logic                                  enable,
  input  wire logic                                  hold,
  input  wire logic [3:0]                            rate_code,
  // Samples
  input  wire logic signed [agoc_pkg::SAMPLE_W-1:0]  sample_in,
  output logic signed [agoc_pkg::SAMPLE_W-1:0]       sample_out,
  output logic signed [agoc_pkg::SAMPLE_W-1:0]       estimate
);

  localparam int ACC_W = agoc_pkg::SAMPLE_W + agoc_pkg::ACC_FRAC;
  localparam logic signed [ACC_W-1:0] ACC_LIM = ACC_W'(EST_LIMIT) <<< agoc_pkg::ACC_FRAC;

  if (EST_LIMIT < 1 || EST_LIMIT > 1023) begin : g_bad_limit
    $error("EST_LIMIT must lie between 1 and 1023");
  end

  logic signed [ACC_W-1:0]              acc_q;
  logic signed [ACC_W-1:0]              step;
  logic signed [ACC_W-1:0]              sum;
  logic signed [agoc_pkg::SAMPLE_W:0]   residual;
  logic [3:0]                           eff_code;
  logic [3:0]                           shift;

  assign estimate = acc_q[ACC_W-1:agoc_pkg::ACC_FRAC];
  assign residual = {sample_in[agoc_pkg::SAMPLE_W-1], sample_in}
                  - {estimate[agoc_pkg::SAMPLE_W-1], estimate};

  // ==========================================================================
  // Loop rate
  // Rate code mapping
  // Reserved codes fall back to the slowest documented rate, the safest choice.
  assign eff_code = (rate_code > 4'(agoc_pkg::RATE_CODE_MAX)) ? 4'(agoc_pkg::RATE_CODE_MAX)
                                                              : rate_code;
  assign shift    = 4'(agoc_pkg::RATE_CODE_MAX) - eff_code;
  assign step     = ACC_W'(residual) <<< shift;
  assign sum      = acc_q + step;

  // ==========================================================================
  // Estimate accumulator
  // First-order accumulator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else if (!enable) begin
      acc_q <= '0;
    end else if (!hold) begin
      if (sum > ACC_LIM) begin
        acc_q <= ACC_LIM;
      end else if (sum < -ACC_LIM) begin
        acc_q <= -ACC_LIM;
      end else begin
        acc_q <= sum;
      end
    end
  end

  // ==========================================================================
  // Correction
  // Subtract while enabled, held or not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_out <= '0;
    end else if (enable) begin
      sample_out <= agoc_pkg::sat_sample(agoc_pkg::WIDE_W'(residual));
    end else begin
      sample_out <= sample_in;
    end
  end

endmodule // agoc_dc_loop

//--- verilog/agoc_gain_stage.sv
module agoc_gain_stage (
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  // Control
  input  wire logic                                  enable,
  input  wire logic [3:0]                            code,
  // Samples
  input  wire logic signed [agoc_pkg::SAMPLE_W-1:0]  sample_in,
  output logic signed [agoc_pkg::SAMPLE_W-1:0]       sample_out
);

  logic signed [agoc_pkg::WIDE_W-1:0] product;
  logic signed [agoc_pkg::WIDE_W-1:0] scaled;

  // ==========================================================================
  // Scaling
  // Proportional full scale
  // Multiplying by 10^(g/20) maps a full-scale input 10^(g/20) times smaller onto full code.
  assign product = agoc_pkg::WIDE_W'(sample_in)
                 * $signed({1'b0, agoc_pkg::gain_factor(code)});
  assign scaled  = product >>> agoc_pkg::GAIN_FRAC;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_out <= '0;
    end else if (enable) begin
      sample_out <= agoc_pkg::sat_sample(scaled);
    end else begin
      sample_out <= sample_in;
    end
  end

endmodule // agoc_gain_stage

//--- verilog/agoc_pkg.sv
package agoc_pkg;

  // ==========================================================================
  // Sample path widths
  localparam int SAMPLE_W    = 11;
  localparam int LVDS_PAIRS  = 6;
  localparam int GAIN_FRAC   = 12;
  localparam int GAIN_FAC_W  = 14;
  localparam int WIDE_W      = 26;

  // ==========================================================================
  // Offset loop timing: the time constant is 2^(LOOP_BASE_LOG2 + code) cycles.
  localparam int LOOP_BASE_LOG2 = 20;
  localparam int RATE_CODE_MAX  = 11;
  localparam int ACC_FRAC       = LOOP_BASE_LOG2 + RATE_CODE_MAX;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE    = 8'h00;
  localparam logic [7:0] ADDR_GAIN    = 8'h04;
  localparam logic [7:0] ADDR_DC_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_EST_A   = 8'h10;
  localparam logic [7:0] ADDR_EST_B   = 8'h14;

  // ==========================================================================
  // Field positions and reset values
  localparam int MODE_DIG1_BIT = 0;
  localparam int MODE_DIG2_BIT = 1;
  localparam int MODE_LVDS_BIT = 2;
  localparam logic MODE_LVDS_RST = 1'b1;
  localparam int GAIN_CODE_LSB = 0;
  localparam int GAIN_CODE_W   = 4;
  localparam logic [3:0] GAIN_CODE_MAX = 4'hC;
  localparam logic [3:0] GAIN_CODE_RST = 4'h0;
  localparam int DC_EN_BIT     = 0;
  localparam int DC_HOLD_BIT   = 1;
  localparam int DC_RATE_LSB   = 4;
  localparam int DC_RATE_W     = 4;
  localparam logic [3:0] DC_RATE_RST = 4'h0;
  localparam int ST_GAIN_BIT   = 0;
  localparam int ST_DC_BIT     = 1;
  localparam int ST_RSVD_BIT   = 2;
  localparam int ST_HOLD_BIT   = 3;

  // Gain factor in Q2.12 for each half-decibel step, 10^(code/40).
  function automatic logic [GAIN_FAC_W-1:0] gain_factor(input logic [3:0] code);
    case (code)
      4'h0:    gain_factor = 14'h1000;
      4'h1:    gain_factor = 14'h10F3;
      4'h2:    gain_factor = 14'h11F4;
      4'h3:    gain_factor = 14'h1304;
      4'h4:    gain_factor = 14'h1425;
      4'h5:    gain_factor = 14'h1556;
      4'h6:    gain_factor = 14'h169A;
      4'h7:    gain_factor = 14'h17F1;
      4'h8:    gain_factor = 14'h195C;
      4'h9:    gain_factor = 14'h1ADC;
      4'hA:    gain_factor = 14'h1C74;
      4'hB:    gain_factor = 14'h1E23;
      default: gain_factor = 14'h1FED;
    endcase
  endfunction

  // Clamp a wide signed value to the two full-scale codes.
  function automatic logic signed [SAMPLE_W-1:0] sat_sample(input logic signed [WIDE_W-1:0] v);
    if (v > 26'sh00003FF) begin
      sat_sample = 11'sh3FF;
    end else if (v < -26'sh0000400) begin
      sat_sample = 11'sh400;
    end else begin
      sat_sample = v[SAMPLE_W-1:0];
    end
  endfunction

endpackage

//--- verilog/agoc_top.sv
module agoc_top #(
  parameter int EST_LIMIT = 10
) (
  // APB slave
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [7:0]                            paddr,
  input  wire logic [31:0]                           pwdata,
  output logic [31:0]                                prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // Converter samples, one per clock per channel
  input  wire logic signed [agoc_pkg::SAMPLE_W-1:0]  ch_a_sample,
  input  wire logic signed [agoc_pkg::SAMPLE_W-1:0]  ch_b_sample,
  // Parallel CMOS outputs
  output logic [agoc_pkg::SAMPLE_W-1:0]              cmos_a_data,
  output logic [agoc_pkg::SAMPLE_W-1:0]              cmos_b_data,
  // DDR LVDS outputs, rising-edge and falling-edge bit per pair
  output logic [agoc_pkg::LVDS_PAIRS-1:0]            lvds_a_rise,
  output logic [agoc_pkg::LVDS_PAIRS-1:0]            lvds_a_fall,
  output logic [agoc_pkg::LVDS_PAIRS-1:0]            lvds_b_rise,
  output logic [agoc_pkg::LVDS_PAIRS-1:0]            lvds_b_fall,
  // Output interface select and clock forwarding
  output logic                                       lvds_mode,
  output logic                                       out_clk_en
);

  localparam int W = agoc_pkg::SAMPLE_W;
  localparam int P = agoc_pkg::LVDS_PAIRS;

  if (2 * P < W) begin : g_bad_pairs
    $error("LVDS_PAIRS too small for the sample width");
  end

  // ==========================================================================
  // Helpers

  // Bit 2k leaves on the rising edge of the output clock.
  function automatic logic [P-1:0] pack_rise(input logic [W-1:0] d);
    logic [P-1:0] r;
    r = '0;
    for (int k = 0; k < P; k++) begin
      if (2 * k < W) begin
        r[k] = d[2*k];
      end
    end
    return r;
  endfunction

  // Bit 2k+1 leaves on the falling edge; the top pair carries zero there.
  function automatic logic [P-1:0] pack_fall(input logic [W-1:0] d);
    logic [P-1:0] r;
    r = '0;
    for (int k = 0; k < P; k++) begin
      if (2 * k + 1 < W) begin
        r[k] = d[2*k+1];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Configuration state
  logic        dig1_q;
  logic        dig2_q;
  logic        lvds_q;
  logic [3:0]  gain_code_q;
  logic        dc_en_q;
  logic        dc_hold_q;
  logic [3:0]  dc_rate_q;
  logic        gain_active_q;
  logic [31:0] prdata_q;

  logic        digital_on;
  logic        gain_active;
  logic        dc_active;
  logic        setup;
  logic        access;
  logic        wr;
  logic        addr_ok;
  logic [31:0] rd_mux;

  logic signed [W-1:0] stage_in  [2];
  logic signed [W-1:0] stage_dc  [2];
  logic signed [W-1:0] stage_out [2];
  logic signed [W-1:0] est       [2];

  assign digital_on  = dig1_q & dig2_q;
  assign gain_active = digital_on;
  assign dc_active   = digital_on & dc_en_q;

  // ==========================================================================
  // APB decode
  // The slave never inserts wait states, so pready follows the access phase.
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign pready  = access;
  assign prdata  = prdata_q;

  always_comb begin
    if (paddr == agoc_pkg::ADDR_MODE) begin
      addr_ok = 1'b1;
    end else if (paddr == agoc_pkg::ADDR_GAIN) begin
      addr_ok = 1'b1;
    end else if (paddr == agoc_pkg::ADDR_DC_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == agoc_pkg::ADDR_STATUS) begin
      addr_ok = 1'b1;
    end else if (paddr == agoc_pkg::ADDR_EST_A) begin
      addr_ok = 1'b1;
    end else if (paddr == agoc_pkg::ADDR_EST_B) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = access & ~addr_ok;

  always_comb begin
    rd_mux = '0;
    if (paddr == agoc_pkg::ADDR_MODE) begin
      rd_mux[agoc_pkg::MODE_DIG1_BIT] = dig1_q;
      rd_mux[agoc_pkg::MODE_DIG2_BIT] = dig2_q;
      rd_mux[agoc_pkg::MODE_LVDS_BIT] = lvds_q;
    end else if (paddr == agoc_pkg::ADDR_GAIN) begin
      rd_mux[agoc_pkg::GAIN_CODE_LSB +: agoc_pkg::GAIN_CODE_W] = gain_code_q;
    end else if (paddr == agoc_pkg::ADDR_DC_CTRL) begin
      rd_mux[agoc_pkg::DC_EN_BIT]   = dc_en_q;
      rd_mux[agoc_pkg::DC_HOLD_BIT] = dc_hold_q;
      rd_mux[agoc_pkg::DC_RATE_LSB +: agoc_pkg::DC_RATE_W] = dc_rate_q;
    end else if (paddr == agoc_pkg::ADDR_STATUS) begin
      rd_mux[agoc_pkg::ST_GAIN_BIT] = gain_active;
      rd_mux[agoc_pkg::ST_DC_BIT]   = dc_active;
      rd_mux[agoc_pkg::ST_RSVD_BIT] = (dc_rate_q > 4'(agoc_pkg::RATE_CODE_MAX));
      rd_mux[agoc_pkg::ST_HOLD_BIT] = dc_active & dc_hold_q;
    end else if (paddr == agoc_pkg::ADDR_EST_A) begin
      rd_mux[W-1:0] = est[0];
    end else if (paddr == agoc_pkg::ADDR_EST_B) begin
      rd_mux[W-1:0] = est[1];
    end
  end

  // Read data is captured in the setup cycle and stands through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // ==========================================================================
  // Mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig1_q <= 1'b0;
      dig2_q <= 1'b0;
      lvds_q <= agoc_pkg::MODE_LVDS_RST;
    end else if (wr && paddr == agoc_pkg::ADDR_MODE) begin
      dig1_q <= pwdata[agoc_pkg::MODE_DIG1_BIT];
      dig2_q <= pwdata[agoc_pkg::MODE_DIG2_BIT];
      lvds_q <= pwdata[agoc_pkg::MODE_LVDS_BIT];
    end
  end

  // ==========================================================================
  // Gain register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_active_q <= 1'b0;
    end else begin
      gain_active_q <= gain_active;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_code_q <= agoc_pkg::GAIN_CODE_RST;
    end else if (gain_active && !gain_active_q) begin
      gain_code_q <= agoc_pkg::GAIN_CODE_RST;
    end else if (wr && gain_active && paddr == agoc_pkg::ADDR_GAIN) begin
      if (pwdata[agoc_pkg::GAIN_CODE_LSB +: agoc_pkg::GAIN_CODE_W] > agoc_pkg::GAIN_CODE_MAX) begin
        gain_code_q <= agoc_pkg::GAIN_CODE_MAX;
      end else begin
        gain_code_q <= pwdata[agoc_pkg::GAIN_CODE_LSB +: agoc_pkg::GAIN_CODE_W];
      end
    end
  end

  // ==========================================================================
  // Offset correction register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_en_q   <= 1'b0;
      dc_hold_q <= 1'b0;
      dc_rate_q <= agoc_pkg::DC_RATE_RST;
    end else if (wr && paddr == agoc_pkg::ADDR_DC_CTRL) begin
      dc_en_q   <= pwdata[agoc_pkg::DC_EN_BIT];
      dc_hold_q <= pwdata[agoc_pkg::DC_HOLD_BIT];
      dc_rate_q <= pwdata[agoc_pkg::DC_RATE_LSB +: agoc_pkg::DC_RATE_W];
    end
  end

  // ==========================================================================
  // Sample path: offset removal first so the loop sees unscaled offset.
  assign stage_in[0] = ch_a_sample;
  assign stage_in[1] = ch_b_sample;

  for (genvar gi = 0; gi < 2; gi++) begin : g_ch
    agoc_dc_loop #(
      .EST_LIMIT (EST_LIMIT)
    ) u_dc (
      .clk        (pclk),
      .rst_n      (presetn),
      .enable     (dc_active),
      .hold       (dc_hold_q),
      .rate_code  (dc_rate_q),
      .sample_in  (stage_in[gi]),
      .sample_out (stage_dc[gi]),
      .estimate   (est[gi])
    );

    agoc_gain_stage u_gain (
      .clk        (pclk),
      .rst_n      (presetn),
      .enable     (gain_active),
      .code       (gain_code_q),
      .sample_in  (stage_dc[gi]),
      .sample_out (stage_out[gi])
    );
  end

  // ==========================================================================
  // Output interface
  // The unused interface is held low so idle pins do not toggle and couple noise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvds_mode   <= agoc_pkg::MODE_LVDS_RST;
      out_clk_en  <= 1'b0;
      cmos_a_data <= '0;
      cmos_b_data <= '0;
      lvds_a_rise <= '0;
      lvds_a_fall <= '0;
      lvds_b_rise <= '0;
      lvds_b_fall <= '0;
    end else begin
      lvds_mode  <= lvds_q;
      out_clk_en <= 1'b1;
      if (lvds_q) begin
        cmos_a_data <= '0;
        cmos_b_data <= '0;
        lvds_a_rise <= pack_rise(stage_out[0]);
        lvds_a_fall <= pack_fall(stage_out[0]);
        lvds_b_rise <= pack_rise(stage_out[1]);
        lvds_b_fall <= pack_fall(stage_out[1]);
      end else begin
        cmos_a_data <= stage_out[0];
        cmos_b_data <= stage_out[1];
        lvds_a_rise <= '0;
        lvds_a_fall <= '0;
        lvds_b_rise <= '0;
        lvds_b_fall <= '0;
      end
    end
  end

endmodule // agoc_top
